// ### verilog/cfc_ctrl.sv
// Feature-disable and clock-gate override control registers in CSR space
`timescale 1ns/1ps
`include "cfc_consts.svh"

module cfc_ctrl #(
    parameter cfc_pkg::cfc_bus_kind_t BUS_KIND = cfc_pkg::CFC_BUS_AHB_LITE
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire cfc_pkg::cfc_csr_req_t csr_req,
    output logic [31:0] csr_rdata,
    output logic csr_hit,
    output cfc_pkg::cfc_feat_t feat_dis,
    output cfc_pkg::cfc_gate_t gate_ovr
);

    // Posted-store reset level is fixed by the bus the core is built for
    localparam logic POSTED_DIS_RST = (BUS_KIND == cfc_pkg::CFC_BUS_AXI4) ?
        `CFC_POSTED_RST_AXI : `CFC_POSTED_RST_AHB;

    // Decoded request qualifiers
    logic sel_feat;
    logic sel_gate;
    logic wr_feat;
    logic wr_gate;
    logic rd_feat;
    logic rd_gate;

    // Feature-disable fields, one flop group per field
    logic [2:0] qos_r;
    logic [2:0] qos_nxt;
    logic ld_fwd_dis_r;
    logic ld_fwd_dis_nxt;
    logic ecc_dis_r;
    logic ecc_dis_nxt;
    logic posted_dis_r;
    logic posted_dis_nxt;
    logic br_pred_dis_r;
    logic br_pred_dis_nxt;
    logic coalesce_dis_r;
    logic coalesce_dis_nxt;
    logic single_issue_r;
    logic single_issue_nxt;
    cfc_pkg::cfc_feat_t feat_wr;
    cfc_pkg::cfc_feat_t feat_cur;

    // Override bits, assembled from the per-bit flops below
    wire logic [`CFC_GO_W-1:0] gate_q;

    // Register images and read path
    logic [31:0] feat_img;
    logic [31:0] gate_img;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    // Address compare used by the hit flag
    function automatic logic is_addr(input logic [11:0] a, input logic [11:0] ref_a);
        is_addr = (a == ref_a);
    endfunction : is_addr

    // Feature fields into register layout; unlisted bits stay zero
    function automatic logic [31:0] feat_word(input cfc_pkg::cfc_feat_t f);
        logic [31:0] w;
        w = `CFC_WORD_ZERO;
        w[`CFC_FD_QOS_HI:`CFC_FD_QOS_LO] = f.dma_qos;
        w[`CFC_FD_LDFWD] = f.ext_load_fwd_dis;
        w[`CFC_FD_ECC] = f.ecc_check_dis;
        w[`CFC_FD_POSTED] = f.side_effect_posted_dis;
        w[`CFC_FD_BRPRED] = f.branch_pred_dis;
        w[`CFC_FD_COALESCE] = f.wb_coalesce_dis;
        w[`CFC_FD_SINGLE] = f.single_issue_mode;
        feat_word = w;
    endfunction : feat_word

    // Register layout into feature fields; reserved bits are dropped
    function automatic cfc_pkg::cfc_feat_t feat_fields(input logic [31:0] w);
        cfc_pkg::cfc_feat_t f;
        f.dma_qos = w[`CFC_FD_QOS_HI:`CFC_FD_QOS_LO];
        f.ext_load_fwd_dis = w[`CFC_FD_LDFWD];
        f.ecc_check_dis = w[`CFC_FD_ECC];
        f.side_effect_posted_dis = w[`CFC_FD_POSTED];
        f.branch_pred_dis = w[`CFC_FD_BRPRED];
        f.wb_coalesce_dis = w[`CFC_FD_COALESCE];
        f.single_issue_mode = w[`CFC_FD_SINGLE];
        feat_fields = f;
    endfunction : feat_fields

    // Override bits into register layout; upper bits have no storage
    function automatic logic [31:0] gate_word(input logic [`CFC_GO_W-1:0] g);
        logic [31:0] w;
        w = `CFC_WORD_ZERO;
        w[`CFC_GO_W-1:0] = g;
        gate_word = w;
    endfunction : gate_word

    // Request decode
    always_comb begin
        sel_feat = 1'b0;
        sel_gate = 1'b0;
        case (csr_req.addr)
            `CFC_FEAT_DIS_ADDR: begin
                sel_feat = 1'b1;
            end
            `CFC_GATE_OVR_ADDR: begin
                sel_gate = 1'b1;
            end
            default: begin
                sel_feat = 1'b0;
            end
        endcase
    end

    // A read beside a write returns the image from before the write
    always_comb begin
        wr_feat = csr_req.wr_en && sel_feat;
        wr_gate = csr_req.wr_en && sel_gate;
        rd_feat = csr_req.rd_en && sel_feat;
        rd_gate = csr_req.rd_en && sel_gate;
    end

    // Only implemented bits are kept, so any written value reads legal
    always_comb begin
        feat_wr = feat_fields(csr_req.wdata);
    end

    // Feature-disable register
    // DMA QoS level; all eight codes are legal
    always_comb begin
        qos_nxt = qos_r;
        if (wr_feat) begin
            qos_nxt = feat_wr.dma_qos;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            qos_r <= `CFC_FD_QOS_RST;
        end else begin
            qos_r <= qos_nxt;
        end
    end

    // External load forwarding off
    always_comb begin
        ld_fwd_dis_nxt = ld_fwd_dis_r;
        if (wr_feat) begin
            ld_fwd_dis_nxt = feat_wr.ext_load_fwd_dis;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ld_fwd_dis_r <= `CFC_FD_BIT_RST;
        end else begin
            ld_fwd_dis_r <= ld_fwd_dis_nxt;
        end
    end

    // Tightly coupled memory ECC checking off
    always_comb begin
        ecc_dis_nxt = ecc_dis_r;
        if (wr_feat) begin
            ecc_dis_nxt = feat_wr.ecc_check_dis;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ecc_dis_r <= `CFC_FD_BIT_RST;
        end else begin
            ecc_dis_r <= ecc_dis_nxt;
        end
    end

    // Side-effect stores wait for their response
    always_comb begin
        posted_dis_nxt = posted_dis_r;
        if (wr_feat) begin
            posted_dis_nxt = feat_wr.side_effect_posted_dis;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            posted_dis_r <= POSTED_DIS_RST;
        end else begin
            posted_dis_r <= posted_dis_nxt;
        end
    end

    // Branch prediction and return stack off
    always_comb begin
        br_pred_dis_nxt = br_pred_dis_r;
        if (wr_feat) begin
            br_pred_dis_nxt = feat_wr.branch_pred_dis;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            br_pred_dis_r <= `CFC_FD_BIT_RST;
        end else begin
            br_pred_dis_r <= br_pred_dis_nxt;
        end
    end

    // Write buffer coalescing off
    always_comb begin
        coalesce_dis_nxt = coalesce_dis_r;
        if (wr_feat) begin
            coalesce_dis_nxt = feat_wr.wb_coalesce_dis;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            coalesce_dis_r <= `CFC_FD_BIT_RST;
        end else begin
            coalesce_dis_r <= coalesce_dis_nxt;
        end
    end

    // One instruction in flight at a time
    always_comb begin
        single_issue_nxt = single_issue_r;
        if (wr_feat) begin
            single_issue_nxt = feat_wr.single_issue_mode;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            single_issue_r <= `CFC_FD_BIT_RST;
        end else begin
            single_issue_r <= single_issue_nxt;
        end
    end

    // One flop per override bit, so no storage exists above the field
    genvar gi;
    generate
        for (gi = 0; gi < `CFC_GO_W; gi++) begin : g_gate_bit
            logic bit_r;
            logic bit_nxt;

            always_comb begin
                bit_nxt = bit_r;
                if (wr_gate) begin
                    bit_nxt = csr_req.wdata[gi];
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    bit_r <= `CFC_GO_BIT_RST;
                end else begin
                    bit_r <= bit_nxt;
                end
            end

            assign gate_q[gi] = bit_r;
        end
    endgenerate

    // Register images as software reads them
    always_comb begin
        feat_img = feat_word(feat_cur);
    end

    always_comb begin
        gate_img = gate_word(gate_q);
    end

    // Misses and idle cycles return zero
    always_comb begin
        rdata_nxt = `CFC_WORD_ZERO;
        case ({rd_feat, rd_gate})
            2'h2: begin
                rdata_nxt = feat_img;
            end
            2'h1: begin
                rdata_nxt = gate_img;
            end
            default: begin
                rdata_nxt = `CFC_WORD_ZERO;
            end
        endcase
    end

    // Registered read data, one cycle after the read request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= `CFC_WORD_ZERO;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Field flops gathered into the output carrier
    always_comb begin
        feat_cur.dma_qos = qos_r;
        feat_cur.ext_load_fwd_dis = ld_fwd_dis_r;
        feat_cur.ecc_check_dis = ecc_dis_r;
        feat_cur.side_effect_posted_dis = posted_dis_r;
        feat_cur.branch_pred_dis = br_pred_dis_r;
        feat_cur.wb_coalesce_dis = coalesce_dis_r;
        feat_cur.single_issue_mode = single_issue_r;
    end

    assign csr_rdata = rdata_r;

    // Hit covers both registers whatever the strobes say
    assign csr_hit = is_addr(csr_req.addr, `CFC_FEAT_DIS_ADDR) ||
                     is_addr(csr_req.addr, `CFC_GATE_OVR_ADDR);

    // Straight from flops: levels move only on the edge after a write lands
    assign feat_dis = feat_cur;
    assign gate_ovr = gate_q;

endmodule : cfc_ctrl

// ### verilog/cfc_consts.svh
// Offsets, field positions and reset values of the feature and clock-gate control bank
`ifndef CFC_CONSTS_SVH
`define CFC_CONSTS_SVH

`define CFC_ADDR_W 12
`define CFC_GATE_OVR_ADDR 12'h7F8
`define CFC_FEAT_DIS_ADDR 12'h7F9

`define CFC_FD_QOS_HI 18
`define CFC_FD_QOS_LO 16
`define CFC_FD_LDFWD 11
`define CFC_FD_ECC 8
`define CFC_FD_POSTED 6
`define CFC_FD_BRPRED 3
`define CFC_FD_COALESCE 2
`define CFC_FD_SINGLE 0
`define CFC_FD_QOS_RST 3'h7
`define CFC_FD_BIT_RST 1'h0
`define CFC_POSTED_RST_AHB 1'h0
`define CFC_POSTED_RST_AXI 1'h1

`define CFC_GO_W 9
`define CFC_GO_RST 9'h000
`define CFC_GO_BIT_RST 1'h0

`define CFC_WORD_ZERO 32'h0000_0000

`endif

// ### verilog/cfc_pkg.sv
// Types for the feature and clock-gate control bank
package cfc_pkg;

    typedef enum logic {
        CFC_BUS_AHB_LITE,
        CFC_BUS_AXI4
    } cfc_bus_kind_t;

    // CSR access from the core's CSR pipeline
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [11:0] addr;
        logic [31:0] wdata;
    } cfc_csr_req_t;

    // Static feature-disable levels
    typedef struct packed {
        logic [2:0] dma_qos;
        logic ext_load_fwd_dis;
        logic ecc_check_dis;
        logic side_effect_posted_dis;
        logic branch_pred_dis;
        logic wb_coalesce_dis;
        logic single_issue_mode;
    } cfc_feat_t;

    // Per-unit clock gating overrides, bit order matches the register
    typedef struct packed {
        logic misc;
        logic decode;
        logic execute;
        logic fetch;
        logic load_store_unit;
        logic bus;
        logic irq_ctrl;
        logic data_mem;
        logic instr_mem;
    } cfc_gate_t;

endpackage : cfc_pkg

// ### testbench/cfc_ctrl_properties.sv
// Checker of the feature and clock-gate control bank
`timescale 1ns/1ps
`include "cfc_consts.svh"
module cfc_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire cfc_pkg::cfc_csr_req_t csr_req,
    input wire logic [31:0] csr_rdata,
    input wire logic csr_hit,
    input wire cfc_pkg::cfc_feat_t feat_dis,
    input wire cfc_pkg::cfc_gate_t gate_ovr
);
    wire logic af = csr_req.addr == `CFC_FEAT_DIS_ADDR;
    wire logic ag = csr_req.addr == `CFC_GATE_OVR_ADDR;
    wire logic wr = csr_req.wr_en;
    wire logic rd = csr_req.rd_en;
    wire logic [31:0] wd = csr_req.wdata;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_dqc; wr && af |=> feat_dis[8:6] == $past(wd[18:16]); endproperty
    a_dqc: assert property (p_dqc) else $error("qos field write");
    property p_fd;
        wr && af |=> feat_dis[5:0] == $past({wd[11], wd[8], wd[6], wd[3:2], wd[0]});
    endproperty
    a_fd: assert property (p_fd) else $error("disable bits write");
    property p_go; wr && ag |=> gate_ovr == $past(wd[8:0]); endproperty
    a_go: assert property (p_go) else $error("gate write");
    property p_hold; !(wr && csr_hit) |=> $stable({feat_dis, gate_ovr}); endproperty
    a_hold: assert property (p_hold) else $error("levels moved");
    property p_rf; rd && af && !wr |=> csr_rdata == {13'h0, feat_dis[8:6], 4'h0,
        feat_dis[5], 2'h0, feat_dis[4], 1'h0, feat_dis[3], 2'h0, feat_dis[2:1], 1'h0, feat_dis[0]};
    endproperty
    a_rf: assert property (p_rf) else $error("feature read image");
    property p_rg; rd && ag && !wr |=> csr_rdata == {23'h0, gate_ovr}; endproperty
    a_rg: assert property (p_rg) else $error("gate read image");
    property p_idle; !(rd && csr_hit) |=> csr_rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("stray read data");
    property p_hit; csr_hit == (af || ag); endproperty
    a_hit: assert property (p_hit) else $error("address decode");
endmodule : cfc_chk
bind cfc_ctrl cfc_chk chk_u (.clk, .rst_n, .csr_req, .csr_rdata, .csr_hit, .feat_dis, .gate_ovr);

// ### testbench/cfc_ctrl_tb.sv
// Self-checking bench of the feature and clock-gate control bank
`timescale 1ns/1ps
`include "cfc_consts.svh"
module cfc_ctrl_tb;
    localparam logic [11:0] FD = `CFC_FEAT_DIS_ADDR;
    localparam logic [11:0] GO = `CFC_GATE_OVR_ADDR;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    cfc_pkg::cfc_csr_req_t req = '0;
    logic [31:0] csr_rdata;
    logic csr_hit;
    cfc_pkg::cfc_feat_t feat_dis;
    cfc_pkg::cfc_gate_t gate_ovr;
    cfc_pkg::cfc_feat_t feat_axi;
    logic [31:0] fd_m = 32'h0007_0000;
    logic [31:0] go_m = 32'h0;
    logic [31:0] exp_q[$];
    logic [31:0] e;
    logic [31:0] seed = 32'hD2DB;
    logic rd_q = 1'b0;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    cfc_ctrl dut_u (.clk, .rst_n, .csr_req(req), .csr_rdata, .csr_hit, .feat_dis, .gate_ovr);
    // Second build only to see the bus-dependent reset level
    cfc_ctrl #(.BUS_KIND(cfc_pkg::CFC_BUS_AXI4)) dut_axi_u (.clk, .rst_n, .csr_req('0),
        .csr_rdata(), .csr_hit(), .feat_dis(feat_axi), .gate_ovr());
    always #2.5 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic stop_test();
        if (fail_count == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test
    // Read sees the old image when a write lands on the same edge
    task automatic op(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{w, r, a, d};
        if (r) exp_q.push_back(a == FD ? fd_m : a == GO ? go_m : 32'h0);
        if (w && a == FD) fd_m = d & 32'h0007_094D;
        if (w && a == GO) go_m = d & 32'h0000_01FF;
    endtask : op
    always @(posedge clk) rd_q <= req.rd_en;
    always @(negedge clk) begin
        if (rd_q) begin
            e = exp_q.pop_front();
            cmp_count++;
            if (csr_rdata !== e) begin
                fail_count++;
                $display("[ERR] csr_rdata exp %h got %h", e, csr_rdata);
            end
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 400) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        cmp_count += 2;
        if (feat_dis !== 9'h1C0 || feat_axi !== 9'h1C8) begin
            fail_count++;
            $display("[ERR] feat reset exp 1c0 1c8 got %h %h", feat_dis, feat_axi);
        end
        if (gate_ovr !== 9'h000) begin
            fail_count++;
            $display("[ERR] gate reset exp 000 got %h", gate_ovr);
        end
        op(0, 1, FD, 0);
        op(0, 1, GO, 0);
        op(0, 0, 0, 0);
        op(1, 1, FD, '1);
        op(0, 0, 0, 0);
        op(1, 1, GO, '1);
        op(0, 1, FD, 0);
        op(0, 1, GO, 0);
        op(1, 0, 12'h7FA, '1);
        repeat (80) begin
            seed = xs(seed);
            op(seed[0], seed[1], seed[3:2] == 2'h0 ? seed[15:4] : {11'h3FC, seed[2]}, xs(seed));
        end
        op(0, 0, 0, 0);
        op(0, 0, 0, 0);
        stop_test();
    end
endmodule : cfc_ctrl_tb
